// ### rtl/pss_top.sv
// Power-up sequencer, supply supervisor and diagnostic timers
// Behaviour
// - Low-supply comparator acted on only after 96 us persistence; open and single-short detection is gated by it with no deglitch
// - Supply undervoltage comparator acted on only after 96 us persistence
// - LED open, short, single-LED short reported after 8 us persistence
// - Each ADC conversion given 57 us before result is complete
// - Blank code zero gives 100 us blanking after channel turn-on
// - Either rail below lockout forces power-on reset of core and registers
// - Each power-on reset sets power-on history and summary fault flags
// - In power-on reset outputs off and fault pin pulled low
// - Both rails good enters init, releases fault pin, starts init timer
// - Init timer length from nonvolatile field; expiry enters normal
// - Clear-history write in init clears flag, stops timer, enters normal
// - Power-up copies nonvolatile settings; others take defaults
// - All channels disabled after power-up
// - Reload-defaults write reloads settings, clears history, self-clears
// - Clear-history write clears the history flag in any state
// - Supply undervoltage disables all channels, holds fault pin, sets flags
// - Supply below low threshold sets low-supply and summary flags
// - Clear-faults command clears low-supply flag with other faults
// - Low supply clears open/single-short faults and suppresses their detection
// - Low threshold is a 5-bit code for 4 V to 35 V in 1 V steps
// - Code zero means lowest threshold, 4.0 V
//
// Implementation choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/100ps
module pss_top #(
    parameter int unsigned N_CH         = 24,
    parameter int unsigned INIT_UNIT    = pss_pkg::INIT_UNIT_CYC
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic [31:0]            hrdata,
    input  wire logic              bat_ok,
    input  wire logic              regulator_output_ok,
    input  wire logic              supply_uv_cmp,
    input  wire logic              supply_low_cmp,
    input  wire logic [N_CH-1:0]   led_open_cmp,
    input  wire logic [N_CH-1:0]   led_short_cmp,
    input  wire logic [N_CH-1:0]   led_sls_cmp,
    input  wire logic [4:0]        nv_low_supply_threshold_code,
    input  wire logic [3:0]        nv_blank_code,
    input  wire logic [7:0]        nv_init_hold_length,
    output logic [4:0]             low_supply_threshold_code,
    output logic [5:0]             low_supply_threshold_volts,
    output logic [N_CH-1:0]        ch_on,
    output logic                   adc_busy,
    output logic                   err_n_o,
    output logic                   err_n_oe
);
    localparam int unsigned CW = pss_pkg::CNT_W;

    // Two-flop synchronisers for analog comparator and rail inputs
    localparam int unsigned NS = 4 + 3 * N_CH;
    logic [NS-1:0] raw_in;
    logic [NS-1:0] s1_ff;
    logic [NS-1:0] s2_ff;
    assign raw_in = {led_sls_cmp, led_short_cmp, led_open_cmp,
                     supply_low_cmp, supply_uv_cmp, regulator_output_ok, bat_ok};
    always_ff @(posedge clk) begin
        s1_ff <= raw_in;
        s2_ff <= s1_ff;
    end
    wire rails_ok = s2_ff[0] & s2_ff[1];
    wire uv_s     = s2_ff[2];
    wire low_s    = s2_ff[3];
    wire [N_CH-1:0] open_s  = s2_ff[4 +: N_CH];
    wire [N_CH-1:0] short_s = s2_ff[4 + N_CH +: N_CH];
    wire [N_CH-1:0] sls_s   = s2_ff[4 + 2*N_CH +: N_CH];

    // AHB-Lite slave: zero wait states, always OKAY
    logic        wr_pend_ff;
    logic [7:0]  addr_ff;
    wire         take = hsel & htrans[1] & hready;
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_pend_ff <= 1'b0;
            addr_ff    <= 8'h00;
        end else begin
            wr_pend_ff <= take & hwrite;
            if (take)
                addr_ff <= haddr[7:0];
        end
    end
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction : hit
    wire wr_ctrl = wr_pend_ff & hit(addr_ff, pss_pkg::OFS_CTRL);
    wire wr_cfg  = wr_pend_ff & hit(addr_ff, pss_pkg::OFS_CONFIG);
    wire wr_chen = wr_pend_ff & hit(addr_ff, pss_pkg::OFS_CHEN);
    wire clr_poh = wr_ctrl & hwdata[pss_pkg::B_CLRPOH];
    wire reload  = wr_ctrl & hwdata[pss_pkg::B_RELOAD];
    wire clr_flt = wr_ctrl & hwdata[pss_pkg::B_CLRFLT];
    wire adc_go  = wr_ctrl & hwdata[pss_pkg::B_ADCGO];

    // Power state machine; reset of core while either rail is low
    pss_pkg::pss_state_t state_ff;
    pss_pkg::pss_state_t nxt_state;
    wire core_rst = rst | ~rails_ok;
    logic [CW-1:0] unit_ff;
    logic [7:0]    hold_ff;
    logic [7:0]    init_len_ff;
    wire unit_tick = (unit_ff == CW'(INIT_UNIT - 1));
    wire init_done = unit_tick & (hold_ff >= init_len_ff);
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            pss_pkg::PSS_POR:    nxt_state = pss_pkg::PSS_INIT;
            pss_pkg::PSS_INIT:
                if (clr_poh | init_done)
                    nxt_state = pss_pkg::PSS_NORMAL;
            pss_pkg::PSS_NORMAL: nxt_state = pss_pkg::PSS_NORMAL;
            default:             nxt_state = pss_pkg::PSS_POR;
        endcase
    end
    always_ff @(posedge clk) begin
        if (core_rst)
            state_ff <= pss_pkg::PSS_POR;
        else
            state_ff <= nxt_state;
    end
    // Init timer counts whole units; stops outside init
    wire in_init = (state_ff == pss_pkg::PSS_INIT);
    always_ff @(posedge clk) begin
        if (core_rst || !in_init) begin
            unit_ff <= '0;
            hold_ff <= 8'h00;
        end else begin
            unit_ff <= unit_tick ? '0 : unit_ff + 1'b1;
            if (unit_tick)
                hold_ff <= hold_ff + 8'h01;
        end
    end

    // Configuration: loaded from nonvolatile image at power-up or reload
    logic [4:0]      lowth_ff;
    logic [3:0]      blank_ff;
    logic [N_CH-1:0] chen_ff;
    logic            loaded_ff;
    wire load_nv = ~loaded_ff | reload;
    always_ff @(posedge clk) begin
        if (core_rst) begin
            loaded_ff   <= 1'b0;
            lowth_ff    <= pss_pkg::LOWTH_RST;
            blank_ff    <= pss_pkg::BLANK_RST;
            init_len_ff <= 8'h00;
            chen_ff     <= '0;
        end else if (load_nv) begin
            // Strap-like nonvolatile image sampled after reset release
            loaded_ff   <= 1'b1;
            lowth_ff    <= nv_low_supply_threshold_code;
            blank_ff    <= nv_blank_code;
            init_len_ff <= nv_init_hold_length;
            chen_ff     <= '0;
        end else begin
            if (wr_cfg) begin
                lowth_ff <= hwdata[pss_pkg::F_LOWTH +: 5];
                blank_ff <= hwdata[pss_pkg::F_BLANK +: 4];
            end
            if (wr_chen)
                chen_ff <= hwdata[N_CH-1:0];
        end
    end
    assign low_supply_threshold_code  = lowth_ff;
    assign low_supply_threshold_volts = 6'(pss_pkg::LOWSUP_BASE_V) + {1'b0, lowth_ff};

    // Deglitch counters for the supply comparators
    logic [CW-1:0] uv_cnt_ff;
    logic [CW-1:0] low_cnt_ff;
    wire uv_q  = (uv_cnt_ff  == CW'(pss_pkg::SUPUV_DEG_CYC));
    wire low_q = (low_cnt_ff == CW'(pss_pkg::SUPLOW_DEG_CYC));
    always_ff @(posedge clk) begin
        if (core_rst) begin
            uv_cnt_ff  <= '0;
            low_cnt_ff <= '0;
        end else begin
            uv_cnt_ff  <= !uv_s ? '0 : (uv_q ? uv_cnt_ff : uv_cnt_ff + 1'b1);
            low_cnt_ff <= !low_s ? '0 : (low_q ? low_cnt_ff : low_cnt_ff + 1'b1);
        end
    end

    // Status flags; a set in the same cycle as a clear wins
    logic poh_ff;
    logic err_ff;
    logic uv_flag_ff;
    logic low_flag_ff;
    logic [N_CH-1:0] open_flt_ff;
    logic [N_CH-1:0] short_flt_ff;
    logic [N_CH-1:0] sls_flt_ff;
    logic [N_CH-1:0] open_q;
    logic [N_CH-1:0] short_q;
    logic [N_CH-1:0] sls_q;
    wire  led_any = |{open_q, short_q, sls_q};
    always_ff @(posedge clk) begin
        if (core_rst) begin
            poh_ff      <= 1'b1;
            err_ff      <= 1'b1;
            uv_flag_ff  <= 1'b0;
            low_flag_ff <= 1'b0;
        end else begin
            poh_ff      <= poh_ff & ~(clr_poh | reload);
            uv_flag_ff  <= uv_q | (uv_flag_ff & ~clr_flt);
            low_flag_ff <= low_q | (low_flag_ff & ~clr_flt);
            err_ff      <= uv_q | low_q | led_any | (err_ff & ~clr_flt);
        end
    end

    // Per-channel blanking and LED deglitch
    logic [CW-1:0] blank_cyc;
    always_comb begin
        unique case (blank_ff)
            4'h0:    blank_cyc = CW'(pss_pkg::BLANK0_CYC);
            4'h1:    blank_cyc = CW'(200);
            4'h2:    blank_cyc = CW'(300);
            4'h3:    blank_cyc = CW'(500);
            4'h4:    blank_cyc = CW'(800);
            4'h5:    blank_cyc = CW'(1500);
            4'h6:    blank_cyc = CW'(2000);
            4'h7:    blank_cyc = CW'(3000);
            4'h8:    blank_cyc = CW'(5000);
            4'h9:    blank_cyc = CW'(8000);
            4'hA:    blank_cyc = CW'(10000);
            4'hB:    blank_cyc = CW'(12000);
            4'hC:    blank_cyc = CW'(15000);
            4'hD:    blank_cyc = CW'(20000);
            4'hE:    blank_cyc = CW'(30000);
            4'hF:    blank_cyc = CW'(40000);
        endcase
    end
    wire out_en = (state_ff == pss_pkg::PSS_NORMAL) & ~uv_flag_ff;
    assign ch_on = chen_ff & {N_CH{out_en}};

    genvar g;
    generate
        for (g = 0; g < N_CH; g++) begin : g_ch
            logic [CW-1:0] blk_ff;
            // Seven bits so the full deglitch count fits
            logic [6:0]    oc_ff;
            logic [6:0]    sc_ff;
            logic [6:0]    lc_ff;
            wire armed = ch_on[g] & (blk_ff == blank_cyc);
            wire op_in = armed & open_s[g] & ~low_s;
            wire sl_in = armed & sls_s[g] & ~low_s;
            wire sh_in = armed & short_s[g];
            assign open_q[g]  = (oc_ff == 7'(pss_pkg::LED_DEG_CYC - 1)) & op_in;
            assign short_q[g] = (sc_ff == 7'(pss_pkg::LED_DEG_CYC - 1)) & sh_in;
            assign sls_q[g]   = (lc_ff == 7'(pss_pkg::LED_DEG_CYC - 1)) & sl_in;
            always_ff @(posedge clk) begin
                if (core_rst || !ch_on[g])
                    blk_ff <= '0;
                else if (blk_ff != blank_cyc)
                    blk_ff <= blk_ff + 1'b1;
            end
            always_ff @(posedge clk) begin
                if (core_rst) begin
                    oc_ff <= 7'h00;
                    sc_ff <= 7'h00;
                    lc_ff <= 7'h00;
                end else begin
                    oc_ff <= (!op_in || open_q[g])  ? 7'h00 : oc_ff + 7'h01;
                    sc_ff <= (!sh_in || short_q[g]) ? 7'h00 : sc_ff + 7'h01;
                    lc_ff <= (!sl_in || sls_q[g])   ? 7'h00 : lc_ff + 7'h01;
                end
            end
            always_ff @(posedge clk) begin
                if (core_rst) begin
                    open_flt_ff[g]  <= 1'b0;
                    short_flt_ff[g] <= 1'b0;
                    sls_flt_ff[g]   <= 1'b0;
                end else begin
                    // Low supply wipes pending open and single-short faults
                    open_flt_ff[g]  <= open_q[g] | (open_flt_ff[g] & ~clr_flt & ~low_q);
                    sls_flt_ff[g]   <= sls_q[g] | (sls_flt_ff[g] & ~clr_flt & ~low_q);
                    short_flt_ff[g] <= short_q[g] | (short_flt_ff[g] & ~clr_flt);
                end
            end
        end
    endgenerate

    // Conversion timer; a start while busy is ignored
    logic [CW-1:0] conv_ff;
    always_ff @(posedge clk) begin
        if (core_rst)
            conv_ff <= '0;
        else if (conv_ff != '0)
            conv_ff <= conv_ff - 1'b1;
        else if (adc_go)
            conv_ff <= CW'(pss_pkg::CONV_CYC);
    end
    assign adc_busy = (conv_ff != '0);

    // Fault pin: pulled low in reset and while the undervoltage flag is set
    assign err_n_o  = 1'b0;
    assign err_n_oe = (state_ff == pss_pkg::PSS_POR) | uv_flag_ff;

    // Read mux
    logic [31:0] rd;
    always_comb begin
        rd = 32'h0000_0000;
        if (hit(addr_ff, pss_pkg::OFS_STATUS))
            rd = {26'h0, state_ff, low_flag_ff, uv_flag_ff, err_ff, poh_ff};
        else if (hit(addr_ff, pss_pkg::OFS_CONFIG))
            rd = {20'h0, blank_ff, 3'h0, lowth_ff};
        else if (hit(addr_ff, pss_pkg::OFS_CHEN))
            rd = 32'(chen_ff);
        else if (hit(addr_ff, pss_pkg::OFS_LEDFLT))
            rd = 32'(open_flt_ff | short_flt_ff | sls_flt_ff);
        else if (hit(addr_ff, pss_pkg::OFS_ADC))
            rd = {31'h0, adc_busy};
    end
    assign hrdata = rd;
endmodule : pss_top

// ### rtl/pss_pkg.sv
// Package of constants for the power startup supervisor
package pss_pkg;
    localparam int unsigned CLK_HZ          = 10_000_000;
    localparam int unsigned NS_PER_CYC      = 1_000_000_000 / CLK_HZ;
    localparam int unsigned SUPLOW_DEG_US   = 96;
    localparam int unsigned SUPUV_DEG_US    = 96;
    localparam int unsigned LED_DEG_US      = 8;
    localparam int unsigned CONV_US         = 57;
    localparam int unsigned BLANK0_US       = 100;
    // Least times round up
    localparam int unsigned SUPLOW_DEG_CYC  = (SUPLOW_DEG_US * 1000 + NS_PER_CYC - 1) / NS_PER_CYC;
    localparam int unsigned SUPUV_DEG_CYC   = (SUPUV_DEG_US * 1000 + NS_PER_CYC - 1) / NS_PER_CYC;
    localparam int unsigned LED_DEG_CYC     = (LED_DEG_US * 1000 + NS_PER_CYC - 1) / NS_PER_CYC;
    localparam int unsigned CONV_CYC        = (CONV_US * 1000 + NS_PER_CYC - 1) / NS_PER_CYC;
    localparam int unsigned BLANK0_CYC      = (BLANK0_US * 1000 + NS_PER_CYC - 1) / NS_PER_CYC;
    localparam int unsigned INIT_UNIT_US    = 1000;
    localparam int unsigned INIT_UNIT_CYC   = (INIT_UNIT_US * 1000) / NS_PER_CYC;
    localparam int unsigned CNT_W           = 16;
    localparam int unsigned LOWSUP_BASE_V   = 4;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL         = 8'h00;
    localparam logic [7:0] OFS_STATUS       = 8'h04;
    localparam logic [7:0] OFS_CONFIG       = 8'h08;
    localparam logic [7:0] OFS_CHEN         = 8'h0C;
    localparam logic [7:0] OFS_LEDFLT       = 8'h10;
    localparam logic [7:0] OFS_ADC          = 8'h14;
    // CTRL bit positions
    localparam int unsigned B_CLRPOH        = 0;
    localparam int unsigned B_RELOAD        = 1;
    localparam int unsigned B_CLRFLT        = 2;
    localparam int unsigned B_ADCGO         = 3;
    // STATUS bit positions
    localparam int unsigned B_POH           = 0;
    localparam int unsigned B_ERR           = 1;
    localparam int unsigned B_SUPUV         = 2;
    localparam int unsigned B_LOWSUP        = 3;
    localparam int unsigned B_STATE         = 4;
    // CONFIG reset / field positions
    localparam int unsigned F_LOWTH         = 0;
    localparam int unsigned F_BLANK         = 8;
    localparam logic [4:0]  LOWTH_RST       = 5'h00;
    localparam logic [3:0]  BLANK_RST       = 4'h0;
    typedef enum logic [1:0] {
        PSS_POR    = 2'b00,
        PSS_INIT   = 2'b01,
        PSS_NORMAL = 2'b11
    } pss_state_t;
endpackage : pss_pkg

// ### dv/pss_host_model.sv
// Host bus master model: single word transfers, flag clears
`timescale 1ns/100ps
module pss_host_model (
    input  wire logic        clk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata
);
    int n_timeouts;
    initial begin
        hsel       = 1'b0;
        haddr      = 32'h00000000;
        htrans     = 2'h0;
        hwrite     = 1'b0;
        hsize      = 3'h2;
        hwdata     = 32'h00000000;
        n_timeouts = 0;
    end
    task automatic xfer(input logic w, input logic [7:0] ofs, input logic [31:0] wd,
                        output logic [31:0] rd);
        int i;
        hsel   <= 1'b1;
        haddr  <= {24'h000000, ofs};
        htrans <= 2'h2;
        hwrite <= w;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (hready === 1'b1) break;
        end
        if (i == 20) n_timeouts++;
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (hready === 1'b1) break;
        end
        if (i == 20) n_timeouts++;
        rd = hrdata;
        // Stale write data inverted so nothing leans on a held bus
        hwdata <= ~wd;
        @(posedge clk);
    endtask : xfer
    task automatic wr(input logic [7:0] ofs, input logic [31:0] wd);
        logic [31:0] d;
        xfer(1'b1, ofs, wd, d);
    endtask : wr
    task automatic rd(input logic [7:0] ofs, output logic [31:0] d);
        xfer(1'b0, ofs, 32'h00000000, d);
    endtask : rd
    task automatic reload();
        wr(pss_pkg::OFS_CTRL, 32'h00000002);
    endtask : reload
    task automatic clr_hist();
        wr(pss_pkg::OFS_CTRL, 32'h00000001);
    endtask : clr_hist
endmodule : pss_host_model

// ### dv/pss_top_sva.sv
// Port checker of the supervisor with its bind
`timescale 1ns/100ps
module pss_chk #(
    parameter int unsigned N_CH      = 24,
    parameter int unsigned INIT_UNIT = 4
) (
    input wire logic            clk,
    input wire logic            rst,
    input wire logic            bat_ok,
    input wire logic            regulator_output_ok,
    input wire logic            supply_uv_cmp,
    input wire logic [4:0]      low_supply_threshold_code,
    input wire logic [5:0]      low_supply_threshold_volts,
    input wire logic [N_CH-1:0] ch_on,
    input wire logic            adc_busy,
    input wire logic            err_n_o,
    input wire logic            err_n_oe
);
    localparam int CONV = pss_pkg::CONV_CYC;
    logic [11:0] uv_cnt_ff;
    logic [11:0] nxt_uv_cnt;
    logic [2:0]  ok_cnt_ff;
    logic [2:0]  nxt_ok_cnt;
    logic [9:0]  adc_cnt_ff;
    logic [9:0]  nxt_adc_cnt;
    wire rails_ok = bat_ok && regulator_output_ok;
    // Saturating so a long trip never wraps back under the limit
    assign nxt_uv_cnt  = !supply_uv_cmp ? 12'h000 : uv_cnt_ff + {11'h000, ~&uv_cnt_ff};
    assign nxt_ok_cnt  = !rails_ok ? 3'h0 : ok_cnt_ff + {2'h0, ~&ok_cnt_ff};
    assign nxt_adc_cnt = adc_busy ? adc_cnt_ff + 10'h001 : 10'h000;
    always_ff @(posedge clk) begin
        uv_cnt_ff  <= rst ? 12'h000 : nxt_uv_cnt;
        ok_cnt_ff  <= rst ? 3'h0 : nxt_ok_cnt;
        adc_cnt_ff <= rst ? 10'h000 : nxt_adc_cnt;
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    property p_por_pin;
        (!rails_ok)[*4] |-> err_n_oe && !err_n_o && ch_on == '0;
    endproperty
    a_por_pin: assert property (p_por_pin) else $error("fault pin or outputs wrong in POR");
    property p_init_release;
        $rose(rails_ok) && uv_cnt_ff == 12'h000 |-> ##[2:6] !err_n_oe;
    endproperty
    a_init_release: assert property (p_init_release) else $error("fault pin not released");
    property p_uv_pin;
        uv_cnt_ff >= 12'd970 |-> err_n_oe && ch_on == '0;
    endproperty
    a_uv_pin: assert property (p_uv_pin) else $error("undervoltage not acted on");
    property p_uv_deg;
        $rose(err_n_oe) |-> uv_cnt_ff >= 12'd960 || ok_cnt_ff < 3'h5;
    endproperty
    a_uv_deg: assert property (p_uv_deg) else $error("fault pin before deglitch");
    property p_thr;
        low_supply_threshold_volts == {1'b0, low_supply_threshold_code} + 6'h04;
    endproperty
    a_thr: assert property (p_thr) else $error("threshold volts mismatch");
    property p_ch_reset;
        $past(rst) |-> ch_on == '0;
    endproperty
    a_ch_reset: assert property (p_ch_reset) else $error("channels on after reset");
    property p_adc_len;
        $fell(adc_busy) |-> adc_cnt_ff == CONV;
    endproperty
    a_adc_len: assert property (p_adc_len) else $error("conversion length wrong");
    property p_adc_max;
        adc_busy |-> adc_cnt_ff < CONV;
    endproperty
    a_adc_max: assert property (p_adc_max) else $error("conversion overran");
    c_uv: cover property (uv_cnt_ff == 12'd970);
    c_adc: cover property ($fell(adc_busy));
    c_por: cover property ((!rails_ok)[*4]);
endmodule : pss_chk
bind pss_top pss_chk #(.N_CH(N_CH), .INIT_UNIT(INIT_UNIT)) u_chk (
    .clk                        (clk),
    .rst                        (rst),
    .bat_ok                     (bat_ok),
    .regulator_output_ok        (regulator_output_ok),
    .supply_uv_cmp              (supply_uv_cmp),
    .low_supply_threshold_code  (low_supply_threshold_code),
    .low_supply_threshold_volts (low_supply_threshold_volts),
    .ch_on                      (ch_on),
    .adc_busy                   (adc_busy),
    .err_n_o                    (err_n_o),
    .err_n_oe                   (err_n_oe)
);

// ### dv/tb_power_startup_supervisor.sv
// Self-checking bench of the power startup supervisor
`timescale 1ns/100ps
module tb_power_startup_supervisor;
    localparam logic [4:0] NV_TH = 5'h07;
    localparam logic [7:0] R_CTRL = pss_pkg::OFS_CTRL;
    localparam logic [7:0] R_STAT = pss_pkg::OFS_STATUS;
    localparam logic [7:0] R_CFG  = pss_pkg::OFS_CONFIG;
    localparam logic [7:0] R_CHEN = pss_pkg::OFS_CHEN;
    localparam logic [7:0] R_LED  = pss_pkg::OFS_LEDFLT;
    logic        clk;
    logic        rst;
    logic        bat_ok;
    logic        rail_ok;
    logic        uv_cmp;
    logic        low_cmp;
    logic [23:0] open_cmp;
    logic [23:0] short_cmp;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
    logic [31:0] hrdata;
    logic [4:0]  th_code;
    logic [5:0]  th_volts;
    logic [23:0] ch_on;
    logic        adc_busy;
    logic        err_n_o;
    logic        err_n_oe;
    int          n_errors;
    int          n_checks;
    int          cyc;
    int          t0;
    pss_host_model u_host (.clk(clk), .hready(hready), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
    pss_top #(.N_CH(24), .INIT_UNIT(8)) DUT (.clk(clk), .rst(rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hready), .hresp(), .hrdata(hrdata), .bat_ok(bat_ok),
        .regulator_output_ok(rail_ok), .supply_uv_cmp(uv_cmp), .supply_low_cmp(low_cmp),
        .led_open_cmp(open_cmp), .led_short_cmp(short_cmp), .led_sls_cmp(24'h000000),
        .nv_low_supply_threshold_code(NV_TH), .nv_blank_code(4'h0),
        .nv_init_hold_length(8'h03), .low_supply_threshold_code(th_code),
        .low_supply_threshold_volts(th_volts), .ch_on(ch_on), .adc_busy(adc_busy),
        .err_n_o(err_n_o), .err_n_oe(err_n_oe));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic rdchk(input logic [7:0] ofs, input logic [31:0] mask, input logic [31:0] exp);
        logic [31:0] d;
        u_host.rd(ofs, d);
        check(d & mask, exp);
    endtask : rdchk
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_cyc
    task automatic t_power_up();
        logic [31:0] d;
        int i;
        check(err_n_oe, 32'h0);
        rdchk(R_STAT, 32'h33, 32'h13);
        rdchk(R_CFG, 32'hF1F, {27'h0, NV_TH});
        rdchk(R_CHEN, 32'hFFFFFF, 32'h0);
        for (i = 0; i < 40; i++) begin
            u_host.rd(R_STAT, d);
            if (d[5:4] === 2'b11) break;
        end
        // Hold of (3+1) units of 8 cycles, plus sync and poll slack
        check(cyc - t0 >= 32 && cyc - t0 <= 44, 32'h1);
        u_host.clr_hist();
        rdchk(R_STAT, 32'h31, 32'h30);
        u_host.reload();
    endtask : t_power_up
    task automatic t_reload();
        u_host.wr(R_CHEN, 32'h00FFFFFF);
        u_host.wr(R_CFG, 32'h0000031F);
        #1;
        check(ch_on, 32'hFFFFFF);
        check(th_volts, 32'h23);
        u_host.wr(R_CFG, 32'h00000000);
        #1;
        check(th_volts, 32'h04);
        u_host.wr(R_CFG, 32'h0000031F);
        u_host.reload();
        #1;
        check(ch_on, 32'h0);
        rdchk(R_CFG, 32'hF1F, {27'h0, NV_TH});
    endtask : t_reload
    task automatic t_por();
        bat_ok <= 1'b0;
        wait_cyc(6);
        check({err_n_oe, err_n_o, ch_on}, 32'h2000000);
        rdchk(R_STAT, 32'h33, 32'h03);
        bat_ok <= 1'b1;
        wait_cyc(5);
        check(err_n_oe, 32'h0);
        rdchk(R_STAT, 32'h31, 32'h11);
        u_host.clr_hist();
        rdchk(R_STAT, 32'h31, 32'h30);
        // Second power cycle so the history flag is set again for reload
        bat_ok <= 1'b0;
        wait_cyc(6);
        bat_ok <= 1'b1;
        wait_cyc(5);
        u_host.reload();
        rdchk(R_STAT, 32'h31, 32'h10);
        u_host.clr_hist();
    endtask : t_por
    task automatic t_led_low();
        u_host.wr(R_CHEN, 32'h00FFFFFF);
        short_cmp <= 24'h000020;
        open_cmp  <= 24'h000004;
        wait_cyc(900);
        rdchk(R_LED, 32'hFFFFFF, 32'h0);
        wait_cyc(140);
        rdchk(R_LED, 32'hFFFFFF, 32'h0);
        wait_cyc(60);
        rdchk(R_LED, 32'hFFFFFF, 32'h24);
        low_cmp <= 1'b1;
        wait_cyc(500);
        low_cmp <= 1'b0;
        wait_cyc(1);
        low_cmp <= 1'b1;
        wait_cyc(900);
        rdchk(R_STAT, 32'h08, 32'h0);
        wait_cyc(70);
        rdchk(R_STAT, 32'h0A, 32'h0A);
        rdchk(R_LED, 32'hFFFFFF, 32'h20);
        low_cmp <= 1'b0;
        // Wait for the qualified trip to drop so the clear is not overridden by a set
        wait_cyc(4);
        u_host.wr(R_CTRL, 32'h00000004);
        rdchk(R_STAT, 32'h08, 32'h0);
        short_cmp <= 24'h000000;
        open_cmp  <= 24'h000000;
    endtask : t_led_low
    task automatic t_uv();
        uv_cmp <= 1'b1;
        wait_cyc(900);
        check({err_n_oe, ch_on}, 32'hFFFFFF);
        wait_cyc(80);
        check({err_n_oe, ch_on}, 32'h1000000);
        rdchk(R_STAT, 32'h06, 32'h06);
        uv_cmp <= 1'b0;
        wait_cyc(4);
        u_host.wr(R_CTRL, 32'h00000004);
        wait_cyc(3);
        check(err_n_oe, 32'h0);
    endtask : t_uv
    task automatic t_adc();
        int i;
        t0 = cyc;
        u_host.wr(R_CTRL, 32'h00000008);
        wait_cyc(100);
        // Second start mid-conversion must not stretch it
        u_host.wr(R_CTRL, 32'h00000008);
        for (i = 0; i < 1000 && adc_busy === 1'b1; i++) wait_cyc(1);
        check(cyc - t0 >= 570 && cyc - t0 <= 576, 32'h1);
    endtask : t_adc
    task automatic print_verdict();
        n_errors += u_host.n_timeouts;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : print_verdict
    initial begin
        {rst, bat_ok, rail_ok, uv_cmp, low_cmp} = 5'b11100;
        open_cmp  = 24'h000000;
        short_cmp = 24'h000000;
        n_errors  = 0;
        n_checks  = 0;
        cyc       = 0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t0 = cyc;
        wait_cyc(1);
        t_power_up();
        t_reload();
        t_por();
        t_led_low();
        u_host.wr(R_CHEN, 32'h00FFFFFF);
        t_uv();
        t_adc();
        print_verdict();
    end
endmodule : tb_power_startup_supervisor
